/* hdl/qrb_pkg.sv */
/*
 Shared constants for the burst-of-four quad-rate SRAM port: data layout,
 byte lanes, latencies, periodic counts and clock-stop timing.
 Assumes the system clock runs at 25 MHz.
*/
package qrb_pkg;
   // ----------------------------------------------------------------
   // Data layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 18;
   localparam int LANES = 2;
   localparam int LANE0_LSB = 0;
   localparam int LANE0_W = 9;
   localparam int LANE1_LSB = 9;
   localparam int LANE1_W = 9;
   localparam int BURST = 4;
   localparam int ADDR_W_DEF = 21;
   // ----------------------------------------------------------------
   // Pipeline ages (cycles after the initiating K rise)
   // ----------------------------------------------------------------
   localparam int RD_FIRST_AGE_NRM = 2;
   localparam int RD_FIRST_AGE_LEG = 1;
   localparam int WR_COMMIT_AGE = 3;
   // ----------------------------------------------------------------
   // Periodic counts and reset values
   // ----------------------------------------------------------------
   localparam int IMP_PERIOD = 1024;
   localparam int IMP_CNT_W = 10;
   localparam int DLL_LOCK_CYCLES = 2048;
   localparam int LOCK_CNT_W = 12;
   localparam logic Q_OE_N_RST = 1'b1;
   // ----------------------------------------------------------------
   // Clock-stop detection on the system clock
   // ----------------------------------------------------------------
   localparam int SYS_PERIOD_NS = 40;
   localparam int CLK_STOP_NS = 30;
   localparam int CLK_STOP_RAW = (CLK_STOP_NS + SYS_PERIOD_NS - 1)
                                 / SYS_PERIOD_NS;
   localparam int CLK_STOP_CYC = (CLK_STOP_RAW < 1) ? 1 : CLK_STOP_RAW;
   localparam int STOP_CNT_W = 4;
   localparam int DLL_RST_HOLD = 3;
endpackage : qrb_pkg

/* hdl/qrb_sync2.sv */
/*
 Two-flop level synchroniser.
 Assumes d_in is a level that is stable long enough to be seen.
*/
`timescale 1ns/1ns
module qrb_sync2
   import qrb_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } qrb_sy_s;
   qrb_sy_s st_q;
   qrb_sy_s st_d;

   // First stage feeds only the second
   always_comb begin
      st_d.s1 = d_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_in) begin
      st_q <= st_d;
   end

   assign q_out = st_q.s2;
endmodule : qrb_sync2

/* hdl/qrb_kbar_reg.sv */
/*
 Register clocked on the rising edge of the negative input clock, taken
 as the falling edge of the positive one. Reset is synchronous.
 Assumes rst_in comes from logic on the same link clock.
*/
`timescale 1ns/1ns
module qrb_kbar_reg
   import qrb_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] val;
   } qrb_kb_s;
   qrb_kb_s st_q;
   qrb_kb_s st_d;

   // Load or reset
   always_comb begin
      st_d.val = rst_in ? RST_VAL : d_in;
   end

   always_ff @(negedge clk_in) begin
      st_q <= st_d;
   end

   assign q_out = st_q.val;
endmodule : qrb_kbar_reg

/* hdl/qrb_sram_port.sv */
/*
 Burst-of-four quad-rate SRAM port: separate read and write ports on one
 address bus, byte masking, forwarding, arbitration, echo clocks, valid
 flag, impedance update and DLL lock. Link logic runs on k_clk_in; the
 system clock carries reset and clock-stop detection.
 Assumes the controller drives pins on the link clock.
*/
// Operation
// - Read starts on low read select.
// - Read returns four words, lowest first.
// - Data at Kbar t+2, K t+3, Kbar t+3, K t+4.
// - Back-to-back read request is ignored.
// - Deselected read port tristates after Kbar.
// - Write starts on low write select.
// - Four write words, then 72-bit commit.
// - Back-to-back write request is ignored.
// - Idle write port ignores its inputs.
// - Byte selects sampled per word, mask lanes.
// - Select 0 bits 8:0, 1 bits 17:9.
// - Read after write forwards newest data with DLL on.
// - Both selected: read unless read before.
// - Both held alternate, read first.
// - Selects sampled on K; a read start blocks a write start.
// - Byte selects captured on both clock rises.
// - Impedance update every 1024 cycles.
// - Two free-running echo clocks.
// - Valid flag half cycle before data; with data in legacy.
// - DLL off gives one-cycle legacy latency.
// - Stopped clock resets the DLL.
// - DLL locks after 2048 stable cycles.
// - Powers up deselected, outputs tristated.
`timescale 1ns/1ns
module qrb_sram_port
   import qrb_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic k_clk_in,
   input wire logic read_port_select_n_in,
   input wire logic write_port_select_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic [LANES-1:0] byte_write_select_n_in,
   input wire logic dll_disable_n_in,
   output logic [DATA_W-1:0] q_k_out,
   output logic [DATA_W-1:0] q_kb_out,
   output logic q_oe_n_out,
   output logic read_data_valid_out,
   output logic echo_clock_out,
   output logic echo_clock_n_out,
   output logic impedance_update_out,
   output logic dll_locked_out,
   output logic k_stopped_out
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int KB_W = DATA_W + LANES;
   localparam int KO_W = DATA_W + 2;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rst_req;
      logic dll_rst;
      logic stopped;
      logic [1:0] gray_seen;
      logic [STOP_CNT_W-1:0] stop_cnt;
      logic [STOP_CNT_W-1:0] hold_cnt;
   } qrb_sys_s;

   typedef struct packed {
      logic [3:0] rv;
      logic [3:0][ADDR_W-1:0] ra;
      logic [2:0] wv;
      logic [2:0][ADDR_W-1:0] wa;
      logic [2:0][DATA_W-1:0] wb;
      logic [2:0][LANES-1:0] wm;
      logic [DATA_W-1:0] q_k;
      logic [DATA_W-1:0] kb_word;
      logic kb_oe_n;
      logic valid;
      logic echo;
      logic [1:0] gray;
      logic [IMP_CNT_W-1:0] imp_cnt;
      logic imp_pulse;
      logic [LOCK_CNT_W-1:0] lock_cnt;
      logic locked;
   } qrb_lnk_s;

   qrb_sys_s sys_q;
   qrb_sys_s sys_d;
   qrb_lnk_s lk_q;
   qrb_lnk_s lk_d;

   logic [DATA_W-1:0] mem [DEPTH];
   logic [1:0] sync_ctl;
   logic link_rst;
   logic dll_rst_l;
   logic dll_en;
   logic [1:0] gray_sys;
   logic [KB_W-1:0] kb_in;
   logic [KO_W-1:0] kb_out;
   logic start_rd;
   logic start_wr;
   logic legacy;
   logic commit;
   logic [4:0] age_v;
   logic [BURST-1:0][DATA_W-1:0] cw;
   logic [BURST-1:0][LANES-1:0] cm;
   logic [ADDR_W-1:0] ca;

   // ----------------------------------------------------------------
   // Crossings and half-cycle registers
   // ----------------------------------------------------------------
   qrb_sync2 #(.W(2)) u_sync_ctl (
      .clk_in(k_clk_in),
      .d_in({sys_q.dll_rst, sys_q.rst_req}),
      .q_out(sync_ctl)
   );
   qrb_sync2 #(.W(1)) u_sync_dll_disable_n (
      .clk_in(k_clk_in),
      .d_in(dll_disable_n_in),
      .q_out(dll_en)
   );
   qrb_sync2 #(.W(2)) u_sync_gray (
      .clk_in(clk_sys_in),
      .d_in(lk_q.gray),
      .q_out(gray_sys)
   );

   // Write data and byte selects at the Kbar rise
   qrb_kbar_reg #(.W(KB_W)) u_kb_in (
      .clk_in(k_clk_in),
      .rst_in(link_rst),
      .d_in({byte_write_select_n_in, wr_data_in}),
      .q_out(kb_in)
   );

   // Kbar read word, drive enable and negative echo clock
   qrb_kbar_reg #(
      .W(KO_W),
      .RST_VAL({1'b0, Q_OE_N_RST, {DATA_W{1'b0}}})
   ) u_kb_out (
      .clk_in(k_clk_in),
      .rst_in(link_rst),
      .d_in({lk_q.echo, lk_q.kb_oe_n, lk_q.kb_word}),
      .q_out(kb_out)
   );

   assign link_rst = sync_ctl[0];
   assign dll_rst_l = sync_ctl[1];

   // ----------------------------------------------------------------
   // System domain: reset request and clock-stop detection
   // ----------------------------------------------------------------
   always_comb begin
      sys_d = sys_q;
      sys_d.rst_req = 1'b0;
      if (gray_sys != sys_q.gray_seen) begin
         sys_d.gray_seen = gray_sys;
         sys_d.stop_cnt = '0;
         sys_d.stopped = 1'b0;
      end else if (sys_q.stop_cnt < STOP_CNT_W'(CLK_STOP_CYC)) begin
         sys_d.stop_cnt = sys_q.stop_cnt + 1'b1;
      end else begin
         sys_d.stopped = 1'b1;
      end
      // Hold the DLL reset long enough for the resumed clock to see it
      if (sys_q.stopped) begin
         sys_d.hold_cnt = STOP_CNT_W'(DLL_RST_HOLD);
      end else if (sys_q.hold_cnt != '0) begin
         sys_d.hold_cnt = sys_q.hold_cnt - 1'b1;
      end
      sys_d.dll_rst = sys_q.stopped || (sys_q.hold_cnt != '0);
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         sys_q <= '{rst_req: 1'b1, default: '0};
      end else begin
         sys_q <= sys_d;
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Burst word address
   function automatic logic [ADDR_W-1:0] burst_addr(
      input logic [ADDR_W-1:0] a,
      input int unsigned i
   );
      burst_addr = a + ADDR_W'(i);
   endfunction : burst_addr

   // Byte-lane merge; a low select stores its lane
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0] sel_n
   );
      merge = old_w;
      if (!sel_n[0]) begin
         merge[LANE0_LSB +: LANE0_W] = new_w[LANE0_LSB +: LANE0_W];
      end
      if (!sel_n[1]) begin
         merge[LANE1_LSB +: LANE1_W] = new_w[LANE1_LSB +: LANE1_W];
      end
   endfunction : merge

   // Array read with the commit of this cycle forwarded
   function automatic logic [DATA_W-1:0] rd_word(
      input logic [ADDR_W-1:0] a
   );
      rd_word = mem[a];
      for (int i = 0; i < BURST; i++) begin
         if (commit && burst_addr(ca, i) == a) begin
            rd_word = merge(rd_word, cw[i], cm[i]);
         end
      end
   endfunction : rd_word

   // ----------------------------------------------------------------
   // Initiation, arbitration and commit data
   // ----------------------------------------------------------------
   assign legacy = !dll_en;
   // Read wins unless a read started on the previous rise
   assign start_rd = !read_port_select_n_in && !lk_q.rv[0];
   assign start_wr = !write_port_select_n_in && !lk_q.wv[0]
                     && !start_rd;
   assign age_v = {lk_q.rv, start_rd};
   assign commit = lk_q.wv[WR_COMMIT_AGE-1];
   assign ca = lk_q.wa[WR_COMMIT_AGE-1];
   assign cw = {kb_in[DATA_W-1:0], lk_q.wb[2], lk_q.wb[1], lk_q.wb[0]};
   assign cm = {kb_in[KB_W-1:DATA_W], lk_q.wm[2], lk_q.wm[1], lk_q.wm[0]};

   // ----------------------------------------------------------------
   // Link domain next state
   // ----------------------------------------------------------------
   always_comb begin
      lk_d = lk_q;
      lk_d.rv = {lk_q.rv[2:0], start_rd};
      lk_d.ra = {lk_q.ra[2:0], addr_in};
      lk_d.wv = {lk_q.wv[1:0], start_wr};
      lk_d.wa = {lk_q.wa[1:0], addr_in};
      // Write words; nothing is taken without a pending write
      if (lk_q.wv[0]) begin
         lk_d.wb[0] = wr_data_in;
         lk_d.wm[0] = byte_write_select_n_in;
      end
      if (lk_q.wv[1]) begin
         lk_d.wb[1] = kb_in[DATA_W-1:0];
         lk_d.wm[1] = kb_in[KB_W-1:DATA_W];
         lk_d.wb[2] = wr_data_in;
         lk_d.wm[2] = byte_write_select_n_in;
      end
      // Read words on the two half-cycle registers
      if (legacy) begin
         if (age_v[RD_FIRST_AGE_LEG]) begin
            lk_d.q_k = rd_word(burst_addr(lk_q.ra[0], 0));
            lk_d.kb_word = rd_word(burst_addr(lk_q.ra[0], 1));
         end else if (age_v[RD_FIRST_AGE_LEG+1]) begin
            lk_d.q_k = rd_word(burst_addr(lk_q.ra[1], 2));
            lk_d.kb_word = rd_word(burst_addr(lk_q.ra[1], 3));
         end
         lk_d.kb_oe_n = !(age_v[0] || age_v[1] || age_v[2]);
         lk_d.valid = age_v[RD_FIRST_AGE_LEG]
                      || age_v[RD_FIRST_AGE_LEG+1];
      end else begin
         if (age_v[RD_FIRST_AGE_NRM]) begin
            lk_d.kb_word = rd_word(burst_addr(lk_q.ra[1], 0));
         end else if (age_v[RD_FIRST_AGE_NRM+1]) begin
            lk_d.kb_word = rd_word(burst_addr(lk_q.ra[2], 2));
         end
         if (age_v[RD_FIRST_AGE_NRM+1]) begin
            lk_d.q_k = rd_word(burst_addr(lk_q.ra[2], 1));
         end else if (age_v[RD_FIRST_AGE_NRM+2]) begin
            lk_d.q_k = rd_word(burst_addr(lk_q.ra[3], 3));
         end
         lk_d.kb_oe_n = !(age_v[2] || age_v[3]);
         lk_d.valid = age_v[RD_FIRST_AGE_NRM]
                      || age_v[RD_FIRST_AGE_NRM+1];
      end
      // Echo clock and gray activity count run free
      lk_d.echo = !lk_q.echo;
      lk_d.gray = {lk_q.gray[0], !lk_q.gray[1]};
      // Periodic impedance update
      lk_d.imp_cnt = lk_q.imp_cnt + 1'b1;
      lk_d.imp_pulse = (lk_q.imp_cnt == IMP_CNT_W'(IMP_PERIOD - 1));
      // DLL lock after stable clock
      if (dll_rst_l || !dll_en) begin
         lk_d.lock_cnt = '0;
         lk_d.locked = 1'b0;
      end else if (lk_q.lock_cnt == LOCK_CNT_W'(DLL_LOCK_CYCLES - 1)) begin
         lk_d.locked = 1'b1;
      end else begin
         lk_d.lock_cnt = lk_q.lock_cnt + 1'b1;
      end
   end

   // Link registers; reset leaves both ports deselected
   always_ff @(posedge k_clk_in) begin
      if (link_rst) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Array commit of all four masked words
   always_ff @(posedge k_clk_in) begin
      if (commit) begin
         for (int i = 0; i < BURST; i++) begin
            mem[burst_addr(ca, i)] <= merge(mem[burst_addr(ca, i)],
                                            cw[i], cm[i]);
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign q_k_out = lk_q.q_k;
   assign q_kb_out = kb_out[DATA_W-1:0];
   assign q_oe_n_out = kb_out[DATA_W];
   assign echo_clock_n_out = kb_out[DATA_W+1];
   assign read_data_valid_out = lk_q.valid;
   assign echo_clock_out = lk_q.echo;
   assign impedance_update_out = lk_q.imp_pulse;
   assign dll_locked_out = lk_q.locked;
   assign k_stopped_out = sys_q.stopped;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_rd_spacing: assert property (@(posedge k_clk_in) disable iff (link_rst)
      start_rd |=> !start_rd) else $error("read started twice");
   a_wr_spacing: assert property (@(posedge k_clk_in) disable iff (link_rst)
      start_wr |=> !start_wr) else $error("write started twice");
   a_arb_write_wins: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      (!read_port_select_n_in && !write_port_select_n_in && lk_q.rv[0])
      |-> start_wr && !start_rd) else $error("write lost");
   a_arb_alternate: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      (!read_port_select_n_in && !write_port_select_n_in
       && !lk_q.rv[0] && !lk_q.wv[0])
      ##1 (!read_port_select_n_in && !write_port_select_n_in)
      |-> start_wr ##1 !read_port_select_n_in |-> start_rd)
      else $error("no alternation");
   a_valid_window: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      (start_rd && dll_en) ##1 dll_en [*2] |-> ##1 read_data_valid_out
      ##1 read_data_valid_out)
      else $error("valid flag misplaced");
   a_first_word: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      (lk_q.rv[1] && dll_en) |=> lk_q.kb_word == $past(rd_word(lk_q.ra[1])))
      else $error("first word wrong");
   a_tristate_idle: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      (lk_q.rv == 4'h0 && $past(lk_q.rv) == 4'h0 && !start_rd)
      |=> q_oe_n_out) else $error("driving while idle");
   a_imp_spacing: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      impedance_update_out |=> !impedance_update_out [*8])
      else $error("update too close");
   a_lock_needs_dll: assert property (@(posedge k_clk_in)
      disable iff (link_rst)
      $rose(dll_locked_out) |-> $past(lk_q.lock_cnt) ==
      LOCK_CNT_W'(DLL_LOCK_CYCLES - 1)) else $error("early lock");
   a_echo_runs: assert property (@(posedge k_clk_in) disable iff (link_rst)
      echo_clock_out |=> !echo_clock_out) else $error("echo stuck");
endmodule : qrb_sram_port

/* testbench/qrb_ctrl_model.sv */
/*
 Controller model for the quad-rate SRAM port: makes the link clock and
 drives selects, address, write data, lane selects and the DLL control.
 Assumes the bench calls one request task at a time, from a K rise.
*/
`timescale 1ns/1ns
module qrb_ctrl_model
   import qrb_pkg::*;
#(
   parameter int AW = 6
) (
   output logic k_clk_out,
   output logic read_port_select_n_out,
   output logic write_port_select_n_out,
   output logic [AW-1:0] addr_out,
   output logic [DATA_W-1:0] wr_data_out,
   output logic [LANES-1:0] byte_write_select_n_out,
   output logic dll_disable_n_out
);
   logic run = 1'b1;
   int wr_gen = 0;

   // Pins deselected at time zero, DLL on
   initial begin
      read_port_select_n_out = 1'b1;
      write_port_select_n_out = 1'b1;
      addr_out = '0;
      wr_data_out = '0;
      byte_write_select_n_out = 2'h3;
      dll_disable_n_out = 1'b1;
   end

   // Link clock, 15 ns period, stands low while stopped
   initial begin
      k_clk_out = 1'b0;
      #3;
      forever begin
         #7;
         k_clk_out = run;
         #8;
         k_clk_out = 1'b0;
      end
   end

   // Present a start on the next K rise
   task automatic issue(input logic r_n, input logic w_n,
                        input logic [AW-1:0] a);
      @(negedge k_clk_out);
      #1;
      read_port_select_n_out = r_n;
      write_port_select_n_out = w_n;
      addr_out = a;
      @(posedge k_clk_out);
   endtask

   // Deselect both ports and scramble the address
   task automatic idle();
      @(negedge k_clk_out);
      #1;
      read_port_select_n_out = 1'b1;
      write_port_select_n_out = 1'b1;
      addr_out = ~addr_out;
   endtask

   // Four write words on K, Kbar, K, Kbar after the start
   task automatic wdata(input logic [4*DATA_W-1:0] d,
                        input logic [4*LANES-1:0] m);
      int g;
      wr_gen++;
      g = wr_gen;
      for (int i = 0; i < 4; i++) begin
         if (i % 2) @(posedge k_clk_out);
         else @(negedge k_clk_out);
         #1;
         wr_data_out = d[i*DATA_W +: DATA_W];
         byte_write_select_n_out = m[i*LANES +: LANES];
      end
      @(negedge k_clk_out);
      #1;
      // Released lines show the inverse unless a newer burst owns them
      if (g == wr_gen) begin
         wr_data_out = ~wr_data_out;
         byte_write_select_n_out = ~byte_write_select_n_out;
      end
   endtask

   // Stop the link clock for a while
   task automatic stop_clk(input int ns);
      @(negedge k_clk_out);
      run = 1'b0;
      #ns;
      run = 1'b1;
   endtask

   // Change the DLL control
   task automatic set_dll(input logic v);
      @(negedge k_clk_out);
      #1;
      dll_disable_n_out = v;
   endtask
endmodule : qrb_ctrl_model

/* testbench/tb.sv */
/*
 Self-checking bench for the quad-rate SRAM port: bursts, masks,
 forwarding, refusals, arbitration, echo, impedance, DLL, clock stop.
 Assumes the controller model drives every link pin.
*/
`timescale 1ns/1ns
module tb
   import qrb_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic k_clk, rps_n, wps_n, dll_n;
   logic [5:0] addr;
   logic [DATA_W-1:0] wd, q_k, q_kb;
   logic [LANES-1:0] bws_n;
   logic oe_n, valid, echo, echo_n, imp, locked, stopped;
   logic [DATA_W-1:0] mem [64];
   int bad_count = 0;
   int compares = 0;

   // System clock, 40 ns period
   always #20 clk_sys = ~clk_sys;

   qrb_sram_port #(
      .ADDR_W(6)
   ) u_qrb_sram_port (
      .clk_sys_in(clk_sys),
      .reset_in(reset),
      .k_clk_in(k_clk),
      .read_port_select_n_in(rps_n),
      .write_port_select_n_in(wps_n),
      .addr_in(addr),
      .wr_data_in(wd),
      .byte_write_select_n_in(bws_n),
      .dll_disable_n_in(dll_n),
      .q_k_out(q_k),
      .q_kb_out(q_kb),
      .q_oe_n_out(oe_n),
      .read_data_valid_out(valid),
      .echo_clock_out(echo),
      .echo_clock_n_out(echo_n),
      .impedance_update_out(imp),
      .dll_locked_out(locked),
      .k_stopped_out(stopped)
   );

   qrb_ctrl_model #(
      .AW(6)
   ) u_qrb_ctrl_model (
      .k_clk_out(k_clk),
      .read_port_select_n_out(rps_n),
      .write_port_select_n_out(wps_n),
      .addr_out(addr),
      .wr_data_out(wd),
      .byte_write_select_n_out(bws_n),
      .dll_disable_n_out(dll_n)
   );

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Print counts and verdict, end the run
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Wait K rises, then let outputs settle
   task automatic k_wait(input int n);
      repeat (n) @(posedge k_clk);
      #2;
   endtask

   // Expected word after lane masking
   function automatic logic [17:0] merge(input logic [17:0] o,
         input logic [17:0] n, input logic [1:0] s);
      merge = o;
      if (!s[0]) merge[8:0] = n[8:0];
      if (!s[1]) merge[17:9] = n[17:9];
   endfunction

   // Start a write and update the expected array
   task automatic wr(input logic r_n, input logic [5:0] a,
                     input logic [71:0] d, input logic [7:0] m);
      u_qrb_ctrl_model.issue(r_n, 1'b0, a);
      fork
         u_qrb_ctrl_model.wdata(d, m);
      join_none
      for (int i = 0; i < 4; i++)
         mem[6'(a+i)] = merge(mem[6'(a+i)], d[i*18 +: 18], m[i*2 +: 2]);
   endtask

   // Watch one read burst; f is the half-edge of word 0
   task automatic rd_chk(input logic [5:0] a, input int f,
                         input logic last);
      for (int j = 1; j <= f + 3; j++) begin
         if (j % 2) @(negedge k_clk);
         else @(posedge k_clk);
         #2;
         if (j >= f) check(j % 2 ? q_kb : q_k, mem[6'(a+j-f)]);
         if (j == f) check(oe_n, 1'b0);
         if (f == 5 && j == 4) check(valid, 1'b1);
         if (last && f == 5 && j == 8) check(valid, 1'b0);
      end
      if (last) begin
         @(negedge k_clk);
         #2;
         check(oe_n, 1'b1);
      end
   endtask

   // Start a read and watch it in the background
   task automatic rd(input logic w_n, input logic [5:0] a, input int f,
                     input logic last);
      u_qrb_ctrl_model.issue(1'b0, w_n, a);
      fork
         rd_chk(a, f, last);
      join_none
   endtask

   // Power-up state, then known contents in six bursts
   task automatic t_init();
      logic [5:0] b [6] = '{6'h3e, 6'h10, 6'h14, 6'h20, 6'h24, 6'h28};
      check(oe_n, 1'b1);
      check(valid, 1'b0);
      check(locked, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wr(1'b1, b[i], 72'h9a5c3cf00d12345678 ^ {12{b[i]}}, 8'h00);
         u_qrb_ctrl_model.idle();
      end
      k_wait(4);
      $display("test init done");
   endtask

   // Seamless reads, the first wrapping the address
   task automatic t_read();
      rd(1'b1, 6'h3e, 5, 1'b0);
      u_qrb_ctrl_model.idle();
      rd(1'b1, 6'h10, 5, 1'b1);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      $display("test read done");
   endtask

   // Lane masks per word, forwarding, garbage after release
   task automatic t_mask();
      wr(1'b1, 6'h14, 72'h3ffff0000012345abc, 8'he4);
      u_qrb_ctrl_model.idle();
      k_wait(4);
      rd(1'b1, 6'h14, 5, 1'b1);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      wr(1'b1, 6'h20, 72'h0c0c0c0c0c0c0c0c0c, 8'h00);
      rd(1'b1, 6'h20, 5, 1'b1);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      $display("test mask done");
   endtask

   // Requests on the rise after a start are ignored
   task automatic t_b2b();
      rd(1'b1, 6'h10, 5, 1'b1);
      u_qrb_ctrl_model.issue(1'b0, 1'b1, 6'h3e);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      wr(1'b1, 6'h24, 72'h111112222233333444, 8'h00);
      u_qrb_ctrl_model.issue(1'b1, 1'b0, 6'h28);
      u_qrb_ctrl_model.idle();
      k_wait(4);
      rd(1'b1, 6'h24, 5, 1'b0);
      u_qrb_ctrl_model.idle();
      rd(1'b1, 6'h28, 5, 1'b1);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      $display("test b2b done");
   endtask

   // Both selects held from idle: read, write, read, write
   task automatic t_both();
      rd(1'b0, 6'h10, 5, 1'b0);
      wr(1'b0, 6'h2c, 72'h2468ace13579bdf024, 8'h00);
      rd(1'b0, 6'h14, 5, 1'b1);
      wr(1'b0, 6'h30, 72'h0fedcba9876543210f, 8'h00);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      rd(1'b1, 6'h2c, 5, 1'b0);
      u_qrb_ctrl_model.idle();
      rd(1'b1, 6'h30, 5, 1'b1);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      $display("test both done");
   endtask

   // Echo clocks, impedance period, lock, clock stop
   task automatic t_misc();
      logic e;
      int n;
      e = echo;
      k_wait(1);
      check(echo, !e);
      @(negedge k_clk);
      #2;
      check(echo_n, echo);
      n = 0;
      while (imp !== 1'b1 && n < 1100) begin
         k_wait(1);
         n++;
      end
      n = 0;
      do begin
         k_wait(1);
         n++;
      end while (imp !== 1'b1 && n < 2000);
      check(n, 1024);
      k_wait(2100);
      check(locked, 1'b1);
      fork
         u_qrb_ctrl_model.stop_clk(400);
         begin
            #300;
            check(stopped, 1'b1);
         end
      join
      k_wait(20);
      check(stopped, 1'b0);
      check(locked, 1'b0);
      $display("test misc done");
   endtask

   // DLL off: one-cycle latency, contents kept over the stop
   task automatic t_legacy();
      u_qrb_ctrl_model.set_dll(1'b0);
      k_wait(5);
      check(locked, 1'b0);
      rd(1'b1, 6'h24, 2, 1'b1);
      u_qrb_ctrl_model.idle();
      k_wait(8);
      u_qrb_ctrl_model.set_dll(1'b1);
      k_wait(5);
      $display("test legacy done");
   endtask

   // Watchdog cuts a hang short
   initial begin
      #600000;
      bad_count++;
      final_report();
   end

   // Reset for five cycles, then the scenarios
   initial begin
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      k_wait(20);
      t_init();
      t_read();
      t_mask();
      t_b2b();
      t_both();
      t_misc();
      t_legacy();
      final_report();
   end
endmodule : tb
